// file: design/tap_detect_and_offset_trim.sv
// Summary of operation
// R1: Tap in progress when any participating axis magnitude reaches tap level.
// R2: Tap max time is the longest above-level excursion that still counts.
// R3: Latency from end of first tap before second-tap span opens.
// R4: Second tap must start within span after latency; may end later.
// R5: Single-only mode fires single tap on fall below level within max time.
// R6: With double enabled, single tap waits until double is settled.
// R7: Suppress bit: above-level sample during latency invalidates double tap.
// R8: Above level when span opens invalidates double tap.
// R9: Second tap longer than max time invalidates double at that limit.
// R10: Tap causes only set when their enable bits are set.
// R11: Each axis takes part only when its axis enable bit is set.
// R12: Host programs gap and span nonzero for double tap to work.
// R13: Host should use gap and span above 0x10 and level above 3 g.
// R14: Tap event records first axis over level; never cleared, only overwritten.
// R15: Detection runs on unfiltered samples at the common sampling rate.
// R16: Link mode alternates: activity sought only after inactivity; the code arms activity first out of reset.
// R17: Reading cause clears activity/inactivity; pending activity blocks autosleep.
// R18: Asleep state shown by a bit in tap source flags.
// R19: Data-ready cause suppressed while asleep.
// R20: Signed 8-bit trim added per axis before output data registers.
// R21: Trim weight fixed; scaled to the active output resolution.
// R22: Trim registers reset to 0x00.
// R23: Each axis output is two's complement, low byte then high byte.
// R24: Tap times counted in whole sample periods, compared once per sample.
`timescale 1ns/1ps
`default_nettype none
`include "tap_trim_params.svh"

module tap_detect_and_offset_trim #(
  parameter int SAMPLE_W = 13
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Unfiltered samples at the internal rate
  input wire logic raw_valid,
  input wire logic signed [SAMPLE_W-1:0] raw_x,
  input wire logic signed [SAMPLE_W-1:0] raw_y,
  input wire logic signed [SAMPLE_W-1:0] raw_z,
  // Filtered, decimated samples for the output registers
  input wire logic out_valid,
  input wire logic signed [15:0] meas_x,
  input wire logic signed [15:0] meas_y,
  input wire logic signed [15:0] meas_z,
  // Activity detector events
  input wire logic act_event,
  input wire logic inact_event,
  // Status
  output logic asleep
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic over_level(input logic signed [SAMPLE_W-1:0] v,
                                      input logic [7:0] lvl);
    logic [SAMPLE_W-1:0] mag;
    logic [15:0] thr;
    mag = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : SAMPLE_W'(v);
    thr = 16'({lvl, 5'h00});
    // Shift kept in step with the header constant
    thr = 16'({8'h00, lvl} << `TAP_LEVEL_SHIFT);
    over_level = 16'(mag) >= thr;
  endfunction

  // Trim LSB is four output LSBs at the finest scale
  function automatic logic [15:0] trim_scaled(input logic [7:0] ofs,
                                              input logic [7:0] mode);
    logic signed [15:0] t;
    t = 16'(signed'(ofs));
    if (mode[`MODE_FULL_RES])
      trim_scaled = t <<< 2;
    else
    begin
      case (mode[1:0])
        2'h0: trim_scaled = t <<< 2;
        2'h1: trim_scaled = t <<< 1;
        2'h2: trim_scaled = t;
        default: trim_scaled = t >>> 1;
      endcase
    end
  endfunction

  // Sum wraps at 16 bits; no saturation, the host owns the headroom
  function automatic logic [15:0] trimmed(input logic [15:0] meas,
                                          input logic [7:0] ofs,
                                          input logic [7:0] mode);
    trimmed = meas + trim_scaled(ofs, mode);
  endfunction

  // Output bytes; reading any of them consumes data ready
  function automatic logic is_out_addr(input logic [5:0] a);
    is_out_addr = (a >= `ADDR_OUT_X_LO) && (a <= `ADDR_OUT_Z_HI);
  endfunction

  // Fixed x, y, z priority when several axes cross on one sample
  function automatic logic [2:0] first_axis_of(input logic [2:0] h);
    if (h[2])
      first_axis_of = 3'h4;
    else if (h[1])
      first_axis_of = 3'h2;
    else
      first_axis_of = 3'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  tap_trim_pkg::trim_state_t s_r;
  tap_trim_pkg::trim_state_t s_nxt;

  logic [2:0] hit;
  logic above;
  logic dbl_on;
  logic single_fire;
  logic double_fire;
  logic cause_rd;
  logic data_rd;
  logic act_ok;
  logic inact_ok;
  logic [8:0] cnt_inc;
  logic [7:0] rd_mux;

  assign reg_rdata = s_r.rdata;
  assign asleep = s_r.asleep;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_nxt = s_r;
    single_fire = 1'b0;
    double_fire = 1'b0;
    cnt_inc = s_r.cnt + 9'h001;
    hit[2] = s_r.tap_axes[`AXES_X] && over_level(raw_x, s_r.tap_level); // R1 R11
    hit[1] = s_r.tap_axes[`AXES_Y] && over_level(raw_y, s_r.tap_level); // R11
    hit[0] = s_r.tap_axes[`AXES_Z] && over_level(raw_z, s_r.tap_level); // R11
    above = |hit; // R1
    // Double tap needs nonzero gap and span
    dbl_on = s_r.irq_en[`CAUSE_DOUBLE] && (s_r.tap_gap != 8'h00)
             && (s_r.tap_span != 8'h00); // R12
    cause_rd = reg_rd && (reg_addr == `ADDR_IRQ_CAUSE);
    data_rd = reg_rd && is_out_addr(reg_addr);

    // Tap sequencer, one step per raw sample
    if (raw_valid) // R15 R24
    begin
      case (s_r.tstate)
        // Wait for any enabled axis to reach level
        tap_trim_pkg::TAP_IDLE:
        begin
          if (above)
          begin
            s_nxt.tstate = tap_trim_pkg::TAP_FIRST;
            s_nxt.cnt = 9'h001;
            // First axis over level, x before y before z
            s_nxt.first_axis = first_axis_of(hit); // R14
          end
        end
        // First excursion, bounded by the max time
        tap_trim_pkg::TAP_FIRST:
        begin
          if (above)
          begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc > {1'b0, s_r.tap_max}) // R2
              s_nxt.tstate = tap_trim_pkg::TAP_WAIT_LOW;
          end
          else if (dbl_on)
          begin
            s_nxt.tstate = tap_trim_pkg::TAP_GAP; // R3 R6
            s_nxt.cnt = 9'h000;
          end
          else
          begin
            single_fire = 1'b1; // R5
            s_nxt.tstate = tap_trim_pkg::TAP_IDLE;
          end
        end
        // Latency after the first tap
        tap_trim_pkg::TAP_GAP:
        begin
          if (above && s_r.tap_axes[`AXES_SUPPRESS])
          begin
            single_fire = 1'b1; // R7 R6
            s_nxt.tstate = tap_trim_pkg::TAP_WAIT_LOW;
          end
          else
          begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc >= {1'b0, s_r.tap_gap}) // R3
            begin
              s_nxt.tstate = tap_trim_pkg::TAP_SPAN;
              s_nxt.cnt = 9'h000;
            end
          end
        end
        // Window in which a second tap may start
        tap_trim_pkg::TAP_SPAN:
        begin
          if (above && (s_r.cnt == 9'h000))
          begin
            // Still high as the span opens
            single_fire = 1'b1; // R8 R6
            s_nxt.tstate = tap_trim_pkg::TAP_WAIT_LOW;
          end
          else if (above)
          begin
            s_nxt.tstate = tap_trim_pkg::TAP_SECOND; // R4
            s_nxt.cnt = 9'h001;
          end
          else
          begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc > {1'b0, s_r.tap_span}) // R4
            begin
              single_fire = 1'b1; // R6
              s_nxt.tstate = tap_trim_pkg::TAP_IDLE;
            end
          end
        end
        // Second excursion, bounded by the max time
        tap_trim_pkg::TAP_SECOND:
        begin
          if (above)
          begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc > {1'b0, s_r.tap_max})
            begin
              single_fire = 1'b1; // R9 R6
              s_nxt.tstate = tap_trim_pkg::TAP_WAIT_LOW;
            end
          end
          else
          begin
            // Second tap may end after the span has closed
            single_fire = 1'b1; // R4 R6
            double_fire = 1'b1;
            s_nxt.tstate = tap_trim_pkg::TAP_IDLE;
          end
        end
        tap_trim_pkg::TAP_WAIT_LOW:
        begin
          // Re-arm only once the excursion is over
          if (!above)
            s_nxt.tstate = tap_trim_pkg::TAP_IDLE;
        end
        default:
        begin
          s_nxt.tstate = tap_trim_pkg::TAP_IDLE;
          s_nxt.cnt = 9'h000;
        end
      endcase
    end

    single_fire = single_fire && s_r.irq_en[`CAUSE_SINGLE]; // R10
    double_fire = double_fire && s_r.irq_en[`CAUSE_DOUBLE]; // R10
    if (single_fire || double_fire)
      s_nxt.tap_src[2:0] = s_r.first_axis; // R14

    // Link mode: activity and inactivity take turns
    act_ok = act_event && (!s_r.mode[`MODE_LINK] || s_r.act_armed); // R16
    inact_ok = inact_event && (!s_r.mode[`MODE_LINK] || !s_r.act_armed); // R16
    if (act_ok)
      s_nxt.act_armed = 1'b0;
    if (inact_ok)
      s_nxt.act_armed = 1'b1;

    // Sticky causes: a read clears, a new event in the same cycle wins
    if (cause_rd)
    begin
      s_nxt.irq_cause[`CAUSE_ACT] = 1'b0; // R17
      s_nxt.irq_cause[`CAUSE_INACT] = 1'b0; // R17
      s_nxt.irq_cause[`CAUSE_SINGLE] = 1'b0;
      s_nxt.irq_cause[`CAUSE_DOUBLE] = 1'b0;
    end
    if (data_rd)
      s_nxt.irq_cause[`CAUSE_DREADY] = 1'b0;
    if (single_fire)
      s_nxt.irq_cause[`CAUSE_SINGLE] = 1'b1;
    if (double_fire)
      s_nxt.irq_cause[`CAUSE_DOUBLE] = 1'b1;
    if (act_ok && s_r.irq_en[`CAUSE_ACT])
      s_nxt.irq_cause[`CAUSE_ACT] = 1'b1;
    if (inact_ok && s_r.irq_en[`CAUSE_INACT])
      s_nxt.irq_cause[`CAUSE_INACT] = 1'b1;

    // Autosleep
    if (act_ok || !s_r.mode[`MODE_AUTOSLEEP])
      s_nxt.asleep = 1'b0;
    else if (inact_ok && !s_r.irq_cause[`CAUSE_ACT]) // R17
      s_nxt.asleep = 1'b1;
    s_nxt.tap_src[`SRC_ASLEEP] = s_nxt.asleep; // R18

    // Output data with trim
    if (out_valid)
    begin
      s_nxt.out_x = trimmed(meas_x, s_r.ofs_x, s_r.mode); // R20 R21
      s_nxt.out_y = trimmed(meas_y, s_r.ofs_y, s_r.mode); // R20 R21
      s_nxt.out_z = trimmed(meas_z, s_r.ofs_z, s_r.mode); // R20 R21
      if (!s_r.asleep && s_r.irq_en[`CAUSE_DREADY])
        s_nxt.irq_cause[`CAUSE_DREADY] = 1'b1; // R19
    end

    // Register writes; read-only and unmapped addresses ignore writes
    if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_TAP_LEVEL: s_nxt.tap_level = reg_wdata;
        `ADDR_OFS_X: s_nxt.ofs_x = reg_wdata;
        `ADDR_OFS_Y: s_nxt.ofs_y = reg_wdata;
        `ADDR_OFS_Z: s_nxt.ofs_z = reg_wdata;
        `ADDR_TAP_MAX: s_nxt.tap_max = reg_wdata;
        `ADDR_TAP_GAP: s_nxt.tap_gap = reg_wdata;
        `ADDR_TAP_SPAN: s_nxt.tap_span = reg_wdata;
        `ADDR_TAP_AXES: s_nxt.tap_axes = {4'h0, reg_wdata[3:0]};
        `ADDR_IRQ_EN: s_nxt.irq_en = {reg_wdata[7:3], 3'h0};
        `ADDR_MODE: s_nxt.mode = {2'h0, reg_wdata[5:3], 1'b0, reg_wdata[1:0]};
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end

    // Register reads, answered in the next cycle only
    case (reg_addr)
      `ADDR_TAP_LEVEL: rd_mux = s_r.tap_level;
      `ADDR_OFS_X: rd_mux = s_r.ofs_x;
      `ADDR_OFS_Y: rd_mux = s_r.ofs_y;
      `ADDR_OFS_Z: rd_mux = s_r.ofs_z;
      `ADDR_TAP_MAX: rd_mux = s_r.tap_max;
      `ADDR_TAP_GAP: rd_mux = s_r.tap_gap;
      `ADDR_TAP_SPAN: rd_mux = s_r.tap_span;
      `ADDR_TAP_AXES: rd_mux = s_r.tap_axes;
      `ADDR_TAP_SRC: rd_mux = s_r.tap_src;
      `ADDR_IRQ_EN: rd_mux = s_r.irq_en;
      `ADDR_IRQ_CAUSE: rd_mux = s_r.irq_cause;
      `ADDR_OUT_X_LO: rd_mux = s_r.out_x[7:0]; // R23
      `ADDR_OUT_X_HI: rd_mux = s_r.out_x[15:8]; // R23
      `ADDR_OUT_Y_LO: rd_mux = s_r.out_y[7:0];
      `ADDR_OUT_Y_HI: rd_mux = s_r.out_y[15:8];
      `ADDR_OUT_Z_LO: rd_mux = s_r.out_z[7:0];
      `ADDR_OUT_Z_HI: rd_mux = s_r.out_z[15:8];
      `ADDR_MODE: rd_mux = s_r.mode;
      default: rd_mux = 8'h00;
    endcase
    s_nxt.rdata = reg_rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Link mode starts out armed for activity
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r <= '0; // R22
      s_r.tstate <= tap_trim_pkg::TAP_IDLE;
      s_r.act_armed <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

endmodule // tap_detect_and_offset_trim
`default_nettype wire

// file: design/tap_trim_params.svh
`ifndef TAP_TRIM_PARAMS_SVH
`define TAP_TRIM_PARAMS_SVH

// Register offsets
`define ADDR_TAP_LEVEL 6'h1D
`define ADDR_OFS_X 6'h1E
`define ADDR_OFS_Y 6'h1F
`define ADDR_OFS_Z 6'h20
`define ADDR_TAP_MAX 6'h21
`define ADDR_TAP_GAP 6'h22
`define ADDR_TAP_SPAN 6'h23
`define ADDR_TAP_AXES 6'h2A
`define ADDR_TAP_SRC 6'h2B
`define ADDR_IRQ_EN 6'h2E
`define ADDR_IRQ_CAUSE 6'h30
`define ADDR_OUT_X_LO 6'h32
`define ADDR_OUT_X_HI 6'h33
`define ADDR_OUT_Y_LO 6'h34
`define ADDR_OUT_Y_HI 6'h35
`define ADDR_OUT_Z_LO 6'h36
`define ADDR_OUT_Z_HI 6'h37
`define ADDR_MODE 6'h3C

// Field positions
`define AXES_SUPPRESS 3
`define AXES_X 2
`define AXES_Y 1
`define AXES_Z 0
`define SRC_ASLEEP 3
`define CAUSE_DREADY 7
`define CAUSE_SINGLE 6
`define CAUSE_DOUBLE 5
`define CAUSE_ACT 4
`define CAUSE_INACT 3
`define MODE_LINK 5
`define MODE_AUTOSLEEP 4
`define MODE_FULL_RES 3

// Reset values
`define RESET_BYTE 8'h00

// Tap level weight relative to sample LSB, as a left shift
`define TAP_LEVEL_SHIFT 5

`endif

// file: design/tap_trim_pkg.sv
package tap_trim_pkg;

  typedef enum logic [5:0] {
    TAP_IDLE = 6'h01,
    TAP_FIRST = 6'h02,
    TAP_GAP = 6'h04,
    TAP_SPAN = 6'h08,
    TAP_SECOND = 6'h10,
    TAP_WAIT_LOW = 6'h20
  } tap_state_t;

  typedef struct packed {
    logic [7:0] tap_level;
    logic [7:0] ofs_x;
    logic [7:0] ofs_y;
    logic [7:0] ofs_z;
    logic [7:0] tap_max;
    logic [7:0] tap_gap;
    logic [7:0] tap_span;
    logic [7:0] tap_axes;
    logic [7:0] tap_src;
    logic [7:0] irq_en;
    logic [7:0] irq_cause;
    logic [7:0] mode;
    tap_state_t tstate;
    logic [8:0] cnt;
    logic [2:0] first_axis;
    logic act_armed;
    logic asleep;
    logic [15:0] out_x;
    logic [15:0] out_y;
    logic [15:0] out_z;
    logic [7:0] rdata;
  } trim_state_t;

endpackage

// file: tb/tap_trim_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tap_trim_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Samples, events, status
  input wire logic raw_valid,
  input wire logic out_valid,
  input wire logic signed [15:0] meas_x,
  input wire logic act_event,
  input wire logic inact_event,
  input wire logic asleep
);
  logic [7:0] trim_r;
  logic [7:0] mode_r;
  logic signed [15:0] exp_x;
  logic ev;
  assign ev = raw_valid || act_event || inact_event;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trim_r <= 8'h00;
      mode_r <= 8'h00;
    end
    else if (reg_wr && reg_addr == 6'h1E)
      trim_r <= reg_wdata;
    else if (reg_wr && reg_addr == 6'h3C)
      mode_r <= reg_wdata;
  end
  // Trim weight is fixed, so its shift follows the output resolution
  always_comb
  begin
    exp_x = 16'(signed'(trim_r));
    if (mode_r[3] || mode_r[1:0] == 2'h0)
      exp_x = exp_x <<< 2;
    else if (mode_r[1:0] == 2'h1)
      exp_x = exp_x <<< 1;
    else if (mode_r[1:0] == 2'h3)
      exp_x = exp_x >>> 1;
    exp_x = exp_x + meas_x;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  trim_rdback_a: assert property (reg_wr && reg_addr == 6'h1E ##1 !reg_wr ##1 reg_rd && reg_addr == 6'h1E
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("trim readback wrong");
  out_lo_a: assert property (out_valid ##1 reg_rd && reg_addr == 6'h32
    |=> {8'h00, reg_rdata} == ($past(exp_x, 2) & 16'h00FF)) else $error("x low byte wrong");
  out_hi_a: assert property (out_valid ##1 reg_rd && reg_addr == 6'h33
    |=> {reg_rdata, 8'h00} == ($past(exp_x, 2) & 16'hFF00)) else $error("x high byte wrong");
  cause_clear_a: assert property (!ev ##1 !ev && reg_rd && reg_addr == 6'h30 ##1 !ev
    ##1 !ev && reg_rd && reg_addr == 6'h30 |=> reg_rdata[6:3] == 4'h0) else $error("cause not cleared");
  wake_act_a: assert property (asleep && act_event |=> !asleep) else $error("no wake on activity");
  sleep_rise_a: assert property ($rose(asleep) |-> $past(inact_event)) else $error("sleep without cause");
  sleep_hold_a: assert property (asleep && !act_event && !(reg_wr && reg_addr == 6'h3C)
    |=> asleep) else $error("sleep dropped");
  src_asleep_a: assert property (reg_rd && reg_addr == 6'h2B
    |=> reg_rdata[3] == $past(asleep)) else $error("asleep flag wrong");
  cover property (out_valid ##1 reg_rd && reg_addr == 6'h33);
  cover property ($rose(asleep));
  cover property (reg_rd && reg_addr == 6'h30 ##1 reg_rdata[5]);
endmodule // tap_trim_sva

bind tap_detect_and_offset_trim tap_trim_sva i_tap_trim_sva (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .raw_valid, .out_valid, .meas_x, .act_event, .inact_event, .asleep);
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Called just after a rising edge; returns just after one
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    // Idle cycle so a following write never touches the strobe twice in one step
    @(posedge ref_clk);
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // Sampled mid-cycle, clear of the edge that ends it
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic raw_valid = 1'b0;
  logic signed [12:0] raw_x = 13'h0000;
  logic signed [12:0] raw_y = 13'h0000;
  logic signed [12:0] raw_z = 13'h0000;
  logic out_valid = 1'b0;
  logic signed [15:0] meas_x = 16'h000A;
  logic signed [15:0] meas_y = 16'hFFF3;
  logic signed [15:0] meas_z = 16'h0009;
  logic act_event = 1'b0;
  logic inact_event = 1'b0;
  logic asleep;
  logic [7:0] rd_byte;
  logic signed [15:0] ex;
  logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0B};
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  tap_detect_and_offset_trim i_tap_detect_and_offset_trim (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .raw_valid, .raw_x, .raw_y, .raw_z, .out_valid, .meas_x, .meas_y,
    .meas_z, .act_event, .inact_event, .asleep);
  host_model i_host_model (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t asleep %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd8(input logic [5:0] a, input logic [7:0] exp);
    i_host_model.rd(a, rd_byte);
    cmp8(rd_byte, exp);
  endtask
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    i_host_model.wr(a, d);
  endtask
  // Other axes stay below level so x alone decides
  task automatic samp(input logic signed [12:0] x, input int n);
    repeat (n)
    begin
      raw_x <= x;
      raw_y <= x >>> 1;
      raw_z <= -(x >>> 2);
      raw_valid <= 1'b1;
      @(posedge ref_clk);
      raw_valid <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic tap(input int n);
    samp(13'h07D0, n);
    samp(13'h0000, 1);
  endtask
  task automatic outp();
    out_valid <= 1'b1;
    @(posedge ref_clk);
    out_valid <= 1'b0;
  endtask
  task automatic ev(input logic a, input logic i);
    act_event <= a;
    inact_event <= i;
    @(posedge ref_clk);
    act_event <= 1'b0;
    inact_event <= 1'b0;
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_trim();
    rd8(6'h1E, 8'h00);
    rd8(6'h20, 8'h00);
    rd8(6'h3F, 8'h00);
    wr8(6'h1E, 8'hFD);
    rd8(6'h1E, 8'hFD);
    wr8(6'h1F, 8'h03);
    wr8(6'h20, 8'hFE);
    foreach (modes[i])
    begin
      wr8(6'h3C, modes[i]);
      ex = 16'(signed'(8'hFD));
      ex = modes[i][3] || modes[i][1:0] == 2'h0 ? ex <<< 2 : modes[i][1:0] == 2'h1 ? ex <<< 1
        : modes[i][1:0] == 2'h3 ? ex >>> 1 : ex;
      ex = ex + meas_x;
      outp();
      rd8(6'h32, ex[7:0]);
      outp();
      rd8(6'h33, ex[15:8]);
    end
    wr8(6'h3C, 8'h00);
    outp();
    rd8(6'h34, 8'hFF);
    rd8(6'h36, 8'h01);
  endtask
  task automatic t_single();
    wr8(6'h1D, 8'h30);
    wr8(6'h21, 8'h03);
    wr8(6'h2A, 8'h04);
    wr8(6'h2E, 8'h40);
    tap(3);
    rd8(6'h30, 8'h40);
    rd8(6'h2B, 8'h04);
    samp(13'h1830, 1);
    samp(13'h0000, 1);
    rd8(6'h30, 8'h40);
    tap(4);
    rd8(6'h30, 8'h00);
    wr8(6'h2A, 8'h03);
    tap(3);
    rd8(6'h30, 8'h00);
    wr8(6'h2A, 8'h04);
    wr8(6'h2E, 8'h00);
    tap(3);
    rd8(6'h30, 8'h00);
    rd8(6'h2B, 8'h04);
  endtask
  task automatic t_double();
    wr8(6'h22, 8'h11);
    wr8(6'h23, 8'h11);
    wr8(6'h2E, 8'h60);
    tap(1);
    samp(13'h0000, 4);
    rd8(6'h30, 8'h00);
    samp(13'h0000, 14);
    tap(1);
    rd8(6'h30, 8'h60);
    tap(1);
    samp(13'h0000, 19);
    tap(4);
    samp(13'h0000, 48);
    rd8(6'h30, 8'h40);
    tap(1);
    samp(13'h07D0, 20);
    samp(13'h0000, 48);
    rd8(6'h30, 8'h40);
    wr8(6'h2A, 8'h0C);
    tap(1);
    samp(13'h0000, 2);
    tap(1);
    samp(13'h0000, 17);
    tap(1);
    samp(13'h0000, 48);
    rd8(6'h30, 8'h40);
  endtask
  task automatic t_sleep();
    wr8(6'h2E, 8'h98);
    wr8(6'h3C, 8'h30);
    outp();
    rd8(6'h30, 8'h80);
    rd8(6'h32, 8'hFE);
    ev(1'b0, 1'b1);
    rd8(6'h30, 8'h00);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    cmp1(asleep, 1'b0);
    rd8(6'h30, 8'h18);
    ev(1'b1, 1'b0);
    rd8(6'h30, 8'h10);
    ev(1'b0, 1'b1);
    cmp1(asleep, 1'b1);
    rd8(6'h2B, 8'h0C);
    outp();
    rd8(6'h30, 8'h08);
    ev(1'b1, 1'b0);
    cmp1(asleep, 1'b0);
    rd8(6'h30, 8'h10);
    rd8(6'h30, 8'h00);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_trim();
    t_single();
    t_double();
    t_sleep();
    close_out();
  end
endmodule // tb
`default_nettype wire
